// *** verilog/dma_channel_pkg.sv ***
// Shared constants and types for the channel control block
package dma_channel_pkg;
  localparam logic [4:0] off_config = 5'h00;
  localparam logic [4:0] off_count = 5'h04;
  localparam logic [4:0] off_periph = 5'h08;
  localparam logic [4:0] off_memory = 5'h0C;
  localparam logic [4:0] off_flags = 5'h10;
  localparam logic [4:0] off_flag_clear = 5'h14;
  localparam int bit_enable = 0;
  localparam int bit_complete_irq = 1;
  localparam int bit_half_irq = 2;
  localparam int bit_error_irq = 3;
  localparam int bit_direction = 4;
  localparam int bit_circular = 5;
  localparam int bit_periph_inc = 6;
  localparam int bit_memory_inc = 7;
  localparam int bit_copy_mode = 14;
  localparam int config_width = 15;
  localparam int flag_any = 0;
  localparam int flag_complete = 1;
  localparam int flag_half = 2;
  localparam int flag_error = 3;
  localparam logic [31:0] reset_word = 32'h0000_0000;
  localparam logic [1:0] size_byte = 2'h0;
  localparam logic [1:0] size_half = 2'h1;
  localparam logic [1:0] size_word = 2'h2;

  typedef struct packed {
    logic [16:0] reserved;
    logic memory_copy_mode;
    logic [1:0] priority_level;
    logic [1:0] memory_element_size;
    logic [1:0] periph_element_size;
    logic memory_addr_increment;
    logic periph_addr_increment;
    logic circular_mode;
    logic direction;
    logic error_irq_enable;
    logic half_irq_enable;
    logic complete_irq_enable;
    logic enable;
  } config_s;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [31:0] wdata;
  } bus_req_s;

  typedef enum logic [1:0] {st_idle, st_read, st_write} xfer_e;
endpackage

// *** verilog/dma_channel_control.sv ***
// One direct memory access channel with APB registers and a bus master
//
// Summary of operation
// - Config bit 0 enables the channel; reset leaves it disabled.
// - Config bit 1 lets the complete flag raise the interrupt.
// - Config bit 2 lets the half flag raise the interrupt.
// - Config bit 3 lets the error flag raise the interrupt.
// - Config bit 4: 0 peripheral to memory, 1 memory to peripheral.
// - Config bit 5 reloads the count after completion.
// - Config bit 6 advances the peripheral address after each transfer.
// - Config bit 7 advances the memory address after each transfer.
// - Bits 9:8 peripheral size 8/16/32; low address bits ignored.
// - Bits 11:10 memory size 8/16/32; low address bits ignored.
// - Bits 13:12 priority from low to very high, offered for arbitration.
// - Bit 14 set copies memory to memory without a request.
// - The count accepts writes only while the channel is disabled.
// - While enabled the count reads remaining and drops per transfer.
// - At completion count stays zero, or reloads in circular mode.
// - A zero count serves no transaction.
// - Global clear bit clears all four flags of the channel.
// - Individual clear bits clear only their own flag.
`timescale 1ns/10ps
module dma_channel_control (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_periph_request,
  output logic o_bus_valid,
  output logic o_bus_write,
  output logic [31:0] o_bus_addr,
  output logic [1:0] o_bus_size,
  output logic [31:0] o_bus_wdata,
  input wire logic i_bus_ready,
  input wire logic i_bus_error,
  input wire logic [31:0] i_bus_rdata,
  input wire logic i_grant,
  output logic o_service_request,
  output logic [1:0] o_priority_level,
  output logic o_irq
);
  dma_channel_pkg::config_s cfg;
  logic [15:0] count;
  logic [15:0] programmed;
  logic [31:0] periph_addr;
  logic [31:0] memory_addr;
  logic [3:0] flags;
  logic [1:0] req_sync;
  dma_channel_pkg::xfer_e state;
  logic addr_in_range;
  logic [31:0] rd_addr;
  logic [31:0] wr_addr;
  logic [1:0] rd_size;
  logic [1:0] wr_size;
  logic [31:0] next_rdata;
  logic apb_write;
  logic apb_read;
  logic done;
  logic bus_fault;
  logic ready_to_serve;
  logic [15:0] next_count;
  logic hit_half;
  logic hit_zero;
  logic [3:0] clear_bits;

  assign apb_write = i_psel && i_penable && i_pwrite && addr_in_range;
  assign addr_in_range = i_paddr[31:5] == 27'h0;
  assign apb_read = i_psel && !i_penable && !i_pwrite;
  assign done = (state == dma_channel_pkg::st_write) && i_bus_ready
    && !i_bus_error;
  assign bus_fault = (state != dma_channel_pkg::st_idle) && i_bus_ready
    && i_bus_error;
  assign ready_to_serve = cfg.enable && (count != 16'h0000)
    && (cfg.memory_copy_mode || req_sync[1]);

  function automatic logic [31:0] align(input logic [31:0] a,
    input logic [1:0] size);
    logic [31:0] r;
    r = a;
    if (size == dma_channel_pkg::size_half) begin
      r[0] = 1'b0;
    end else if (size == dma_channel_pkg::size_word) begin
      r[1:0] = 2'h0;
    end
    return r;
  endfunction

  function automatic logic [31:0] step(input logic [1:0] size);
    logic [31:0] r;
    r = 32'h0000_0001;
    if (size == dma_channel_pkg::size_half) begin
      r = 32'h0000_0002;
    end else if (size == dma_channel_pkg::size_word) begin
      r = 32'h0000_0004;
    end
    return r;
  endfunction

  // Source and target follow the direction bit
  always_comb begin
    if (cfg.direction) begin
      rd_addr = align(memory_addr, cfg.memory_element_size);
      rd_size = cfg.memory_element_size;
      wr_addr = align(periph_addr, cfg.periph_element_size);
      wr_size = cfg.periph_element_size;
    end else begin
      rd_addr = align(periph_addr, cfg.periph_element_size);
      rd_size = cfg.periph_element_size;
      wr_addr = align(memory_addr, cfg.memory_element_size);
      wr_size = cfg.memory_element_size;
    end
  end

  // Count after one transfer, with circular reload
  always_comb begin
    next_count = count - 16'h0001;
    if (next_count == 16'h0000 && cfg.circular_mode) begin
      next_count = programmed;
    end
  end

  assign hit_half = done && ((count - 16'h0001) == (programmed >> 1))
    && (programmed > 16'h0001);
  assign hit_zero = done && (count == 16'h0001);

  always_comb begin
    clear_bits = 4'h0;
    if (apb_write && i_paddr[4:0] == dma_channel_pkg::off_flag_clear) begin
      if (i_pwdata[dma_channel_pkg::flag_any]) begin
        clear_bits = 4'hF;
      end else begin
        clear_bits = i_pwdata[3:0];
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (!addr_in_range) begin
      next_rdata = 32'h0000_0000;
    end else if (i_paddr[4:0] == dma_channel_pkg::off_config) begin
      next_rdata = cfg;
    end else if (i_paddr[4:0] == dma_channel_pkg::off_count) begin
      next_rdata = {16'h0000, count};
    end else if (i_paddr[4:0] == dma_channel_pkg::off_periph) begin
      next_rdata = periph_addr;
    end else if (i_paddr[4:0] == dma_channel_pkg::off_memory) begin
      next_rdata = memory_addr;
    end else if (i_paddr[4:0] == dma_channel_pkg::off_flags) begin
      next_rdata = {28'h0000000, flags};
    end
  end

  // Request pin synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_sync <= 2'h0;
    end else begin
      req_sync <= {req_sync[0], i_periph_request};
    end
  end

  // APB answers in the access cycle, read data set up one cycle earlier
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= dma_channel_pkg::reset_word;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && (i_paddr[31:5] != 27'h0
        || i_paddr[1:0] != 2'h0 || i_paddr[4:2] > 3'h5);
      if (apb_read) begin
        o_prdata <= next_rdata;
      end
    end
  end

  // Configuration register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= dma_channel_pkg::reset_word;
    end else if (bus_fault) begin
      cfg.enable <= 1'b0;
    end else if (apb_write
      && i_paddr[4:0] == dma_channel_pkg::off_config) begin
      cfg <= {17'h0, i_pwdata[dma_channel_pkg::config_width-1:0]};
    end
  end

  // Count and its reload value
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= 16'h0000;
      programmed <= 16'h0000;
    end else if (done) begin
      count <= next_count;
    end else if (apb_write && !cfg.enable
      && i_paddr[4:0] == dma_channel_pkg::off_count) begin
      count <= i_pwdata[15:0];
      programmed <= i_pwdata[15:0];
    end
  end

  // Address registers, stepped per completed transfer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      periph_addr <= dma_channel_pkg::reset_word;
      memory_addr <= dma_channel_pkg::reset_word;
    end else if (done) begin
      if (cfg.periph_addr_increment) begin
        periph_addr <= periph_addr + step(cfg.periph_element_size);
      end
      if (cfg.memory_addr_increment) begin
        memory_addr <= memory_addr + step(cfg.memory_element_size);
      end
    end else if (apb_write && !cfg.enable) begin
      if (i_paddr[4:0] == dma_channel_pkg::off_periph) begin
        periph_addr <= i_pwdata;
      end else if (i_paddr[4:0] == dma_channel_pkg::off_memory) begin
        memory_addr <= i_pwdata;
      end
    end
  end

  // Event flags: a set in the same cycle wins over a clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags <= 4'h0;
    end else begin
      flags[dma_channel_pkg::flag_complete] <= hit_zero
        || (flags[dma_channel_pkg::flag_complete]
        && !clear_bits[dma_channel_pkg::flag_complete]);
      flags[dma_channel_pkg::flag_half] <= hit_half
        || (flags[dma_channel_pkg::flag_half]
        && !clear_bits[dma_channel_pkg::flag_half]);
      flags[dma_channel_pkg::flag_error] <= bus_fault
        || (flags[dma_channel_pkg::flag_error]
        && !clear_bits[dma_channel_pkg::flag_error]);
      flags[dma_channel_pkg::flag_any] <= hit_zero || hit_half || bus_fault
        || (flags[dma_channel_pkg::flag_any]
        && !clear_bits[dma_channel_pkg::flag_any]);
    end
  end

  // Interrupt line gated by the enables
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (flags[dma_channel_pkg::flag_complete]
        && cfg.complete_irq_enable)
        || (flags[dma_channel_pkg::flag_half] && cfg.half_irq_enable)
        || (flags[dma_channel_pkg::flag_error]
        && cfg.error_irq_enable);
    end
  end

  // Arbitration request and rank
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_service_request <= 1'b0;
      o_priority_level <= 2'h0;
    end else begin
      o_service_request <= ready_to_serve
        && state == dma_channel_pkg::st_idle;
      o_priority_level <= cfg.priority_level;
    end
  end

  // Read then write, one element per grant
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= dma_channel_pkg::st_idle;
      o_bus_valid <= 1'b0;
      o_bus_write <= 1'b0;
      o_bus_addr <= dma_channel_pkg::reset_word;
      o_bus_size <= 2'h0;
      o_bus_wdata <= dma_channel_pkg::reset_word;
    end else begin
      case (state)
        dma_channel_pkg::st_idle: begin
          if (ready_to_serve && i_grant && o_service_request) begin
            state <= dma_channel_pkg::st_read;
            o_bus_valid <= 1'b1;
            o_bus_write <= 1'b0;
            o_bus_addr <= rd_addr;
            o_bus_size <= rd_size;
          end
        end
        dma_channel_pkg::st_read: begin
          if (bus_fault) begin
            state <= dma_channel_pkg::st_idle;
            o_bus_valid <= 1'b0;
          end else if (i_bus_ready) begin
            state <= dma_channel_pkg::st_write;
            o_bus_write <= 1'b1;
            o_bus_addr <= wr_addr;
            o_bus_size <= wr_size;
            o_bus_wdata <= i_bus_rdata;
          end
        end
        dma_channel_pkg::st_write: begin
          if (i_bus_ready) begin
            state <= dma_channel_pkg::st_idle;
            o_bus_valid <= 1'b0;
            o_bus_write <= 1'b0;
          end
        end
        default: begin
          state <= dma_channel_pkg::st_idle;
        end
      endcase
    end
  end
endmodule

// *** test/dma_channel_checker.sv ***
// Concurrent checks on the channel control block ports
`timescale 1ns/10ps
module dma_channel_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic [31:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_bus_valid,
  input wire logic o_bus_write,
  input wire logic [31:0] o_bus_addr,
  input wire logic [1:0] o_bus_size,
  input wire logic i_bus_ready,
  input wire logic i_bus_error,
  input wire logic i_grant,
  input wire logic o_service_request
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  property p_answer;
    i_psel && !i_penable |=> o_pready; endproperty
  a_answer: assert property (p_answer) else $error("no apb answer");
  property p_unmapped;
    i_psel && !i_penable && i_paddr > 32'h14 |=> o_pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no slave error");
  property p_rd_wr;
    o_bus_valid && !o_bus_write && i_bus_ready && !i_bus_error
      |=> o_bus_valid && o_bus_write; endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("no write beat");
  property p_wr_end;
    o_bus_valid && o_bus_write && i_bus_ready |=> !o_bus_valid; endproperty
  a_wr_end: assert property (p_wr_end) else $error("no idle gap");
  property p_hold;
    o_bus_valid && !i_bus_ready |=> o_bus_valid && $stable(o_bus_addr)
      && $stable(o_bus_size) && $stable(o_bus_write); endproperty
  a_hold: assert property (p_hold) else $error("beat moved");
  property p_align;
    o_bus_valid |-> (o_bus_size != 2'h2 || o_bus_addr[1:0] == 2'h0)
      && (o_bus_size != 2'h1 || !o_bus_addr[0]); endproperty
  a_align: assert property (p_align) else $error("misaligned");
  property p_err_stop;
    o_bus_valid && i_bus_ready && i_bus_error |=> !o_bus_valid [*3];
  endproperty
  a_err_stop: assert property (p_err_stop) else $error("ran on");
  property p_granted;
    $rose(o_bus_valid) |-> $past(i_grant && o_service_request); endproperty
  a_granted: assert property (p_granted) else $error("no grant");
endmodule
bind dma_channel_control dma_channel_checker i_dma_channel_checker (
  .i_clk, .i_rst_n, .i_psel, .i_penable, .i_paddr, .o_pready, .o_pslverr,
  .o_bus_valid, .o_bus_write, .o_bus_addr, .o_bus_size, .i_bus_ready,
  .i_bus_error, .i_grant, .o_service_request);

// *** test/bus_mem_model.sv ***
// System bus model answering read and write beats
`timescale 1ns/10ps
module bus_mem_model (
  input wire logic i_clk,
  input wire logic i_valid,
  input wire logic [31:0] i_addr,
  input wire logic i_slow,
  input wire logic i_fail,
  output logic o_ready = 1'b0,
  output logic o_error = 1'b0,
  output logic [31:0] o_rdata = 32'h0
);
  logic [1:0] wait_cnt = 2'h0;
  always @(posedge i_clk) begin
    o_ready <= 1'b0;
    o_error <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_valid && !o_ready) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (wait_cnt >= {i_slow, i_slow}) begin
        o_ready <= 1'b1;
        o_error <= i_fail;
        o_rdata <= i_addr ^ 32'h5A5A_0000;
        wait_cnt <= 2'h0;
      end
    end
  end
endmodule

// *** test/dma_channel_control_tb.sv ***
// Self-checking bench for the channel control block
`timescale 1ns/10ps
module dma_channel_control_tb;
  logic i_clk = 1'b0;
  logic i_rst_n, i_psel, i_penable, i_pwrite, i_periph_request, i_grant;
  logic i_bus_ready, i_bus_error, o_pready, o_pslverr, o_bus_valid;
  logic o_bus_write, o_service_request, o_irq, slow, fail, serr;
  logic [31:0] i_paddr, i_pwdata, o_prdata, o_bus_addr, o_bus_wdata;
  logic [31:0] i_bus_rdata, r, pa, ma, v;
  logic [1:0] o_bus_size, o_priority_level;
  logic [15:0] lf = 16'hD717;
  logic [63:0] exp_q[$];
  logic [63:0] ex;
  logic [33:0] last_rd;
  int failures, n_checks, beats, k;
  always #5 i_clk = ~i_clk;
  dma_channel_control i_dma_channel_control (.i_clk, .i_rst_n, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_prdata,
    .o_pslverr, .i_periph_request, .o_bus_valid, .o_bus_write, .o_bus_addr,
    .o_bus_size, .o_bus_wdata, .i_bus_ready, .i_bus_error, .i_bus_rdata,
    .i_grant, .o_service_request, .o_priority_level, .o_irq);
  bus_mem_model i_bus_mem_model (.i_clk, .i_valid(o_bus_valid),
    .i_addr(o_bus_addr), .i_slow(slow), .i_fail(fail),
    .o_ready(i_bus_ready), .o_error(i_bus_error), .o_rdata(i_bus_rdata));
  task automatic check(string nm, logic [63:0] s, logic [63:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic apb(input logic w, input logic [31:0] a, d);
    k = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (o_pready !== 1'b1) failures++;
    r = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [31:0] a, e, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, r, e);
  endtask
  task automatic wait_beats(input int n);
    k = 0;
    while (beats < n && k < 400) begin
      @(posedge i_clk);
      k++;
    end
    check("beats", beats, n);
  endtask
  always @(posedge i_clk) begin
    i_grant <= o_service_request;
    if (o_bus_valid && i_bus_ready && !o_bus_write)
      last_rd <= {o_bus_size, o_bus_addr};
    if (o_bus_valid && i_bus_ready && o_bus_write && exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      check("beat", {o_bus_addr, o_bus_wdata}, ex);
    end
    if (o_bus_valid && i_bus_ready && o_bus_write)
      beats <= beats + 1;
  end
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    i_rst_n = 1'b0;
    {i_psel, i_penable, i_pwrite, i_periph_request, slow, fail} = 6'h0;
    i_paddr = 32'h0;
    i_pwdata = 32'h0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < 6; i++)
      rd(32'(4 * i), 32'h0, "reset value");
    apb(1'b0, 32'h18, 32'h0);
    check("unmapped", serr, 1'b1);
    apb(1'b1, 32'h20, 32'h0000_4001);
    check("unmapped", serr, 1'b1);
    rd(32'h0, 32'h0, "alias write");
    $display("done: reset values");
    for (int i = 0; i < 4; i++) begin
      lf = nxt(lf);
      v = {17'h0, lf[15], i[1:0], lf[11:1], 1'b0};
      apb(1'b1, 32'h0, v);
      rd(32'h0, v, "config");
      check("priority", o_priority_level, i[1:0]);
    end
    $display("done: config fields");
    lf = nxt(lf);
    pa = {lf, 16'h5673};
    ma = {~lf, 16'h1002};
    for (int i = 0; i < 4; i++)
      exp_q.push_back({{ma[31:2], 2'h0} + 32'(4 * i),
        {pa[31:2], 2'h0} ^ 32'h5A5A_0000});
    apb(1'b1, 32'h0, 32'h0);
    apb(1'b1, 32'h8, pa);
    apb(1'b1, 32'hC, ma);
    apb(1'b1, 32'h4, 32'h4);
    beats = 0;
    slow <= 1'b1;
    i_periph_request <= 1'b1;
    apb(1'b1, 32'h0, 32'h0000_0A87);
    apb(1'b1, 32'h4, 32'h9);
    wait_beats(4);
    repeat (30) @(posedge i_clk);
    check("beats", beats, 4);
    rd(32'h4, 32'h0, "count");
    rd(32'h8, pa, "periph address");
    rd(32'hC, ma + 32'h10, "memory address");
    rd(32'h10, 32'h7, "flags");
    check("irq", o_irq, 1'b1);
    apb(1'b1, 32'h14, 32'h2);
    rd(32'h10, 32'h5, "flags");
    check("irq", o_irq, 1'b1);
    apb(1'b1, 32'h14, 32'h1);
    rd(32'h10, 32'h0, "flags");
    check("irq", o_irq, 1'b0);
    $display("done: single run");
    apb(1'b1, 32'h0, 32'h0);
    apb(1'b1, 32'h4, 32'h2);
    apb(1'b1, 32'hC, ma);
    for (int i = 0; i < 3; i++)
      exp_q.push_back({{ma[31:2], 2'h0} + 32'(4 * i),
        ({pa[31:2], 2'h0} + 32'(4 * i)) ^ 32'h5A5A_0000});
    beats = 0;
    apb(1'b1, 32'h0, 32'h0000_0AE1);
    wait_beats(2);
    i_periph_request <= 1'b0;
    rd(32'h4, 32'h2, "reload");
    repeat (20) @(posedge i_clk);
    check("beats", beats, 3);
    rd(32'h4, 32'h1, "count");
    rd(32'h10, 32'h7, "flags");
    check("irq", o_irq, 1'b0);
    apb(1'b1, 32'h0, 32'h0);
    apb(1'b1, 32'h14, 32'h1);
    rd(32'h10, 32'h0, "flags");
    $display("done: circular run");
    apb(1'b1, 32'h4, 32'h2);
    apb(1'b1, 32'hC, ma | 32'h1);
    fail <= 1'b1;
    apb(1'b1, 32'h0, 32'h0000_4419);
    k = 0;
    while (o_irq !== 1'b1 && k < 100) begin
      @(posedge i_clk);
      k++;
    end
    fail <= 1'b0;
    check("source", last_rd, {2'h1, ma});
    rd(32'h10, 32'h9, "flags");
    rd(32'h0, 32'h4418, "config");
    $display("done: bus error");
    tally_and_finish();
  end
endmodule
